/* hw/vfd_scan.sv */
`timescale 1ns/1ps
`include "vfd_defines.svh"
module vfd_scan #(
  parameter int UNIT_CYC = `VFD_UNIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [31:0] hv_in,
  output logic [31:0] hv_out,
  output logic [31:0] hv_oe,
  output logic hv_slew_slow
);
  import vfd_pkg::*;

  localparam int PW = 16;

  if (UNIT_CYC < 1 || UNIT_CYC > 4096) begin : g_chk
    $error("vfd_scan UNIT_CYC out of range");
  end

  logic [7:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d, ctl3_q, ctl3_d;
  logic [7:0] rdata_q, rdata_d;
  vfd_pins_t latch_q, latch_d;
  logic in_buf;
  logic buf_wr;

  vfd_state_e state_q, state_d;
  logic [3:0] slot_q, slot_d;
  logic run_q, run_d;
  logic gate_q, gate_d;
  vfd_pins_t out_q, out_d;
  logic slow_q, slow_d;

  logic running;
  logic [2:0] dtime;
  logic [3:0] brightness_period;
  logic [3:0] slots;
  logic [4:0] ows;
  logic [PW-1:0] pre_limit;
  logic [PW-1:0] pre_cnt;
  logic pre_wrap;
  logic [3:0] sub_cnt;
  logic sub_wrap;
  logic [31:0] word;
  vfd_pins_t gmask;

  assign dtime = ctl1_q[`VFD_DTIME_LSB +: 3];
  assign brightness_period = ctl2_q[`VFD_DIM_LSB +: 4];
  assign slots = ctl2_q[`VFD_SLOTS_LSB +: 4];
  assign ows = ctl3_q[`VFD_OWS_LSB +: 5];
  assign running = (state_q == VFD_RUN);
  assign in_buf = (reg_addr >= `VFD_BUF_BASE) && (reg_addr <= `VFD_BUF_LAST);
  assign buf_wr = reg_wr && in_buf;

  // register file
  always_comb begin
    ctl1_d = ctl1_q;
    ctl2_d = ctl2_q;
    ctl3_d = ctl3_q;
    latch_d = latch_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `VFD_CTRL1: ctl1_d = reg_wdata;
        `VFD_CTRL2: ctl2_d = reg_wdata;
        `VFD_CTRL3: ctl3_d = reg_wdata;
        default: begin
          if (reg_addr[11:2] == 10'(`VFD_LATCH_BASE >> 2)) begin
            latch_d[8*reg_addr[1:0] +: 8] = reg_wdata;
          end
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `VFD_CTRL1: rdata_d = ctl1_q;
        `VFD_CTRL2: rdata_d = ctl2_q;
        `VFD_CTRL3: rdata_d = ctl3_q;
        `VFD_STATUS: rdata_d = {3'h0, running, slot_q};
        default: begin
          // buffer area reads as zero: refresh only
          if (reg_addr[11:2] == 10'(`VFD_LATCH_BASE >> 2)) begin
            rdata_d = latch_q[8*reg_addr[1:0] +: 8];
          end else if (reg_addr[11:2] == 10'(`VFD_PIN_BASE >> 2)) begin
            rdata_d = hv_in[8*reg_addr[1:0] +: 8];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_q <= `VFD_CTRL1_RST;
      ctl2_q <= `VFD_CTRL2_RST;
      ctl3_q <= `VFD_CTRL3_RST;
      latch_q <= `VFD_LATCH_RST;
      rdata_q <= 8'h00;
    end else begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      ctl3_q <= ctl3_d;
      latch_q <= latch_d;
      rdata_q <= rdata_d;
    end
  end

  // slot time is (dtime + 1) * UNIT_CYC cycles per sub-tick, 16 sub-ticks
  assign pre_limit = PW'((32'(dtime) + 32'd1) * 32'(UNIT_CYC) - 32'd1);

  vfd_count #(.W(PW)) u_pre (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(!running),
    .en(running),
    .limit(pre_limit),
    .cnt_q(pre_cnt),
    .wrap(pre_wrap)
  );

  vfd_count #(.W(4)) u_sub (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(!running),
    .en(pre_wrap),
    .limit(4'(`VFD_SUBTICKS - 1)),
    .cnt_q(sub_cnt),
    .wrap(sub_wrap)
  );

  // buffer word n holds the four bytes of slot n
  vfd_buf_mem #(.WORDS(16)) u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(buf_wr),
    .wr_word(reg_addr[3:0]),
    .wr_lane(reg_addr[5:4]),
    .wr_byte(reg_wdata),
    .rd_word(slot_q),
    .rd_data_q(word)
  );

  // grid mask: codes 0..15 give 1..16 low grids, upper codes none
  always_comb begin
    gmask = 32'h0000_0000;
    if (ows < `VFD_GRID_CODES) begin
      gmask = 32'((33'h1 << (6'(ows) + 6'd1)) - 33'h1);
    end
  end

  // scan and outputs
  always_comb begin
    state_d = ctl1_q[`VFD_BLANK_BIT] ? VFD_IDLE : VFD_RUN;
    slot_d = slot_q;
    if (!running) begin
      slot_d = 4'h0;
    end else if (sub_wrap) begin
      slot_d = (slot_q >= slots) ? 4'h0 : slot_q + 4'h1;
    end
    // gate and run are delayed to line up with the memory read
    run_d = running;
    gate_d = running && (sub_cnt <= brightness_period);
    out_d = latch_q;
    if (run_q) begin
      // a set bit lights its output; grids blank past the dimmer
      out_d = latch_q | (word & ~(gate_q ? 32'h0000_0000 : gmask));
    end
    slow_d = ctl3_q[`VFD_SLOW_BIT];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= VFD_IDLE;
      slot_q <= 4'h0;
      run_q <= 1'b0;
      gate_q <= 1'b0;
      out_q <= 32'h0000_0000;
      slow_q <= 1'b0;
    end else begin
      state_q <= state_d;
      slot_q <= slot_d;
      run_q <= run_d;
      gate_q <= gate_d;
      out_q <= out_d;
      slow_q <= slow_d;
    end
  end

  // source open drain: the pin is driven only where it goes high
  assign hv_out = out_q;
  assign hv_oe = out_q;
  assign hv_slew_slow = slow_q;
  assign reg_rdata = rdata_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_blank_off;
    run_q == 1'b0 |=> out_q == $past(latch_q);
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("blanked outputs not latch only");

  property p_start;
    $fell(ctl1_q[`VFD_BLANK_BIT]) |=> ##1 run_q;
  endproperty
  a_start: assert property (p_start) else $error("scan did not start after unblank");

  property p_slot_step;
    running && sub_wrap && ctl1_q[`VFD_BLANK_BIT] == 1'b0
      |=> slot_q == (($past(slot_q) >= $past(slots)) ? 4'h0 : $past(slot_q) + 4'h1);
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot did not advance or wrap");

  property p_slot_hold;
    running && !sub_wrap && !ctl1_q[`VFD_BLANK_BIT] |=> $stable(slot_q);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot moved inside its time");

  property p_map;
    run_q |=> ((out_q & ~$past(latch_q)) & ~$past(word)) == 32'h0000_0000;
  endproperty
  a_map: assert property (p_map) else $error("output lit without buffer bit");

  property p_seg_copy;
    run_q |=> ((out_q ^ ($past(word) | $past(latch_q))) & ~$past(gmask)) == 32'h0000_0000;
  endproperty
  a_seg_copy: assert property (p_seg_copy) else $error("segment output differs from buffer");

  property p_latch;
    1'b1 |=> (out_q & $past(latch_q)) == $past(latch_q);
  endproperty
  a_latch: assert property (p_latch) else $error("port latch not on output");

  property p_dim;
    running && sub_cnt > brightness_period |=> ##1 (out_q & $past(gmask) & ~$past(latch_q)) == 32'h0000_0000;
  endproperty
  a_dim: assert property (p_dim) else $error("grid lit past dimmer");

  property p_dim_wr;
    reg_wr && reg_addr == `VFD_CTRL2 |=> brightness_period == $past(reg_wdata[3:0]);
  endproperty
  a_dim_wr: assert property (p_dim_wr) else $error("brightness write lost");

  property p_slow;
    reg_wr && reg_addr == `VFD_CTRL3 |=> ##1 hv_slew_slow == $past(reg_wdata[0], 2);
  endproperty
  a_slow: assert property (p_slow) else $error("edge slowdown not applied");

  property p_buf_rd;
    reg_rd && in_buf |=> reg_rdata == 8'h00;
  endproperty
  a_buf_rd: assert property (p_buf_rd) else $error("buffer area read not zero");

  property p_ctl_rd;
    reg_rd && reg_addr == `VFD_CTRL1 && !reg_wr |=> reg_rdata == $past(ctl1_q);
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control one readback wrong");

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_idle_slot;
    !running |=> slot_q == 4'h0;
  endproperty
  a_idle_slot: assert property (p_idle_slot) else $error("slot moved while blanked");

  property p_latch_wr;
    reg_wr && reg_addr == (`VFD_LATCH_BASE + 12'h001) |=> latch_q[15:8] == $past(reg_wdata);
  endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("port latch write lost");

  c_wrap: cover property (running && sub_wrap && slot_q == slots);
  c_dim: cover property (running && gate_q ##1 !gate_q && run_q);
  c_unblank: cover property ($fell(ctl1_q[`VFD_BLANK_BIT]) ##2 run_q);
  c_slot_one: cover property (running && slot_q == 4'h1 && sub_wrap);
endmodule : vfd_scan

/* include/vfd_defines.svh */
`ifndef VFD_DEFINES_SVH
`define VFD_DEFINES_SVH

`define VFD_ADDR_W 12
`define VFD_BUF_BASE 12'hf80
`define VFD_BUF_LAST 12'hfbf
`define VFD_CTRL1 12'hf70
`define VFD_CTRL2 12'hf71
`define VFD_CTRL3 12'hf72
`define VFD_STATUS 12'hf73
`define VFD_LATCH_BASE 12'hf74
`define VFD_PIN_BASE 12'hf78

`define VFD_CTRL1_RST 8'h01
`define VFD_CTRL2_RST 8'h00
`define VFD_CTRL3_RST 8'h00
`define VFD_LATCH_RST 32'h0000_0000

`define VFD_BLANK_BIT 0
`define VFD_DTIME_LSB 1
`define VFD_LINES_LSB 4
`define VFD_DIM_LSB 0
`define VFD_SLOTS_LSB 4
`define VFD_SLOW_BIT 0
`define VFD_OWS_LSB 1

`define VFD_SUBTICKS 16
`define VFD_UNIT_CYC 32
`define VFD_GRID_CODES 5'h10

`endif

/* include/vfd_pkg.sv */
package vfd_pkg;

  typedef enum logic [0:0] {
    VFD_IDLE = 1'b0,
    VFD_RUN = 1'b1
  } vfd_state_e;

  typedef logic [31:0] vfd_pins_t;

endpackage : vfd_pkg

/* hw/vfd_count.sv */
`timescale 1ns/1ps
module vfd_count #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] cnt_q,
  output logic wrap
);
  logic [W-1:0] cnt_d;

  if (W < 1 || W > 24) begin : g_chk
    $error("vfd_count width out of range");
  end

  // >= so a limit lowered mid-count still wraps
  assign wrap = en && (cnt_q >= limit);

  always_comb begin
    cnt_d = cnt_q;
    if (clr || wrap) begin
      cnt_d = '0;
    end else if (en) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : vfd_count

/* hw/vfd_buf_mem.sv */
`timescale 1ns/1ps
module vfd_buf_mem #(
  parameter int WORDS = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(WORDS)-1:0] wr_word,
  input wire logic [1:0] wr_lane,
  input wire logic [7:0] wr_byte,
  input wire logic [$clog2(WORDS)-1:0] rd_word,
  output logic [31:0] rd_data_q
);
  // no reset on the array: contents are undefined after power-up
  logic [31:0] mem [WORDS];

  if (WORDS < 2) begin : g_chk
    $error("vfd_buf_mem needs at least two words");
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_word][8*wr_lane +: 8] <= wr_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 32'h0000_0000;
    end else begin
      rd_data_q <= mem[rd_word];
    end
  end
endmodule : vfd_buf_mem

/* sim/vfd_tube.sv */
`timescale 1ns/1ps
module vfd_tube (
  input wire logic [31:0] hv_out,
  input wire logic [31:0] hv_oe,
  input wire logic [31:0] ext_drv,
  output logic [31:0] hv_in
);
  import vfd_pkg::*;
  // released lines fall to the pull-down rail, never hold the last level
  assign hv_in = (hv_out & hv_oe) | ext_drv;
endmodule : vfd_tube

/* sim/test_vfd_scan.sv */
`timescale 1ns/1ps
`include "vfd_defines.svh"
module test_vfd_scan;
  import vfd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic hv_slew_slow;
  vfd_pins_t hv_in, hv_out, hv_oe;
  vfd_pins_t ext_drv = '0;
  vfd_pins_t exp_w [4];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;

  always #12.5 clk_sys = ~clk_sys;

  // unit of one cycle makes a slot 16 cycles at display time zero
  vfd_scan #(.UNIT_CYC(1)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hv_in(hv_in),
    .hv_out(hv_out), .hv_oe(hv_oe), .hv_slew_slow(hv_slew_slow));
  vfd_tube tube_u (.hv_out(hv_out), .hv_oe(hv_oe), .ext_drv(ext_drv), .hv_in(hv_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(32'(d), 32'(e));
  endtask : rd_chk

  task automatic t_reset;
    chk(hv_out, '0);
    chk(32'(hv_slew_slow), 32'h0);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(`VFD_CTRL1, `VFD_CTRL1_RST);
    rd_chk(`VFD_CTRL2, `VFD_CTRL2_RST);
    rd_chk(`VFD_CTRL3, `VFD_CTRL3_RST);
    for (int i = 0; i < 4; i++) rd_chk(12'hf74 + 12'(i), 8'h00);
  endtask : t_reset

  task automatic t_regs;
    wr(`VFD_CTRL1, 8'hfb);
    rd_chk(`VFD_CTRL1, 8'hfb);
    wr(`VFD_CTRL3, 8'h07);
    #1 chk(32'(hv_slew_slow), 32'h1);
    @(posedge clk_sys);
    rd_chk(`VFD_CTRL3, 8'h07);
    wr(`VFD_STATUS, 8'hff);
    rd_chk(`VFD_STATUS, 8'h00);
    rd_chk(12'hf81, 8'h00);
    rd_chk(12'hf7c, 8'h00);
  endtask : t_regs

  task automatic t_scan;
    for (int n = 0; n < 4; n++) begin
      exp_w[n] = {8'hc0 | 8'(n), 8'ha0 | 8'(n), 8'h50 | 8'(n), 8'h01 << n};
      for (int k = 0; k < 4; k++) wr(12'hf80 + 12'(16 * k + n), exp_w[n][8*k +: 8]);
    end
    wr(`VFD_CTRL1, 8'h01);
    wr(`VFD_CTRL2, 8'h3f);
    wr(`VFD_CTRL3, 8'h06);
    wr(`VFD_CTRL1, 8'h00);
    repeat (9) @(posedge clk_sys);
    // sample mid-slot, clear of the two-cycle output lag
    for (int s = 0; s < 9; s++) begin
      #1 chk(hv_out, exp_w[s % 4]);
      if (s == 4) begin
        exp_w[1][23:16] = 8'h3c;
        @(posedge clk_sys);
        wr(12'hfa1, 8'h3c);
        repeat (13) @(posedge clk_sys);
      end else begin
        repeat (16) @(posedge clk_sys);
      end
    end
  endtask : t_scan

  task automatic t_dim;
    logic [7:0] d;
    int lit;
    wr(`VFD_CTRL2, 8'h33);
    for (int i = 0; i < 2; i++) begin
      wr(`VFD_CTRL3, i ? 8'h20 : 8'h06);
      repeat (4) @(posedge clk_sys);
      lit = 0;
      repeat (16) begin
        #1 lit += int'(hv_out[3:0] != 4'h0);
        @(posedge clk_sys);
      end
      chk(32'(lit), i ? 32'h10 : 32'h4);
    end
    rd(`VFD_STATUS, d);
    chk(32'(d & 8'hf0), 32'h10);
  endtask : t_dim

  task automatic t_slot;
    wr(`VFD_CTRL1, 8'h03);
    wr(12'hf80, 8'h03);
    wr(12'hfb0, 8'h00);
    exp_w[0][7:0] = 8'h03;
    exp_w[0][31:24] = 8'h00;
    ext_drv <= 32'h5a00_0000;
    wr(`VFD_CTRL1, 8'h02);
    rd_chk(12'hf7b, 8'h5a);
    #1 chk(hv_out, exp_w[0]);
    repeat (28) @(posedge clk_sys);
    // display time one stretches a slot to 32 cycles: probe both ends
    rd_chk(`VFD_STATUS, 8'h10);
    rd_chk(`VFD_STATUS, 8'h11);
    ext_drv <= '0;
  endtask : t_slot

  task automatic t_ports;
    wr(`VFD_CTRL1, 8'h01);
    repeat (3) @(posedge clk_sys);
    #1 chk(hv_out, '0);
    @(posedge clk_sys);
    rd_chk(`VFD_STATUS, 8'h00);
    wr(12'hf75, 8'ha5);
    repeat (4) @(posedge clk_sys);
    chk(hv_out, 32'h0000_a500);
    chk(hv_oe, 32'h0000_a500);
    rd_chk(12'hf79, 8'ha5);
    wr(12'hf75, 8'h00);
    ext_drv <= 32'h0000_3c00;
    repeat (4) @(posedge clk_sys);
    rd_chk(12'hf79, 8'h3c);
    // a reset with the scan blanked must drop a loaded port latch
    wr(12'hf76, 8'h81);
    repeat (2) @(posedge clk_sys);
    chk(hv_out, 32'h0081_0000);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    chk(hv_out, '0);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(12'hf76, 8'h00);
    rd_chk(`VFD_CTRL1, `VFD_CTRL1_RST);
  endtask : t_ports

  task automatic wrap_up;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (16) @(posedge clk_sys);
    t_reset;
    t_regs;
    t_scan;
    t_dim;
    t_slot;
    t_ports;
    wrap_up;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up;
    end
  end
endmodule : test_vfd_scan
